/* File: hw/adcp_map.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: system clock of 40 ns
// Notes: shared by both ends of the converter output port
`ifndef ADCP_MAP_SVH
`define ADCP_MAP_SVH

// ----------------------------------------
// word and pipeline
// ----------------------------------------
`define ADCP_WORD_W 16
`define ADCP_LATENCY 7
`define ADCP_NOISE_INJECT_ENABLE_W 4
`define ADCP_LFSR_SEED 16'hace1

// ----------------------------------------
// timing
// ----------------------------------------
`define ADCP_CLK_NS 40
`define ADCP_DCS_HALF_NS 160
`define ADCP_DCS_HALF_CYC \
    ((`ADCP_DCS_HALF_NS + `ADCP_CLK_NS - 1) / `ADCP_CLK_NS)
`define ADCP_LINK_HALF_NS 160
`define ADCP_LINK_HALF_CYC (`ADCP_LINK_HALF_NS / `ADCP_CLK_NS)

// ----------------------------------------
// controller registers
// ----------------------------------------
`define ADCP_REG_CTRL 4'h0
`define ADCP_REG_DATA 4'h4
`define ADCP_REG_STAT 4'h8
`define ADCP_REG_MASK 4'hc
`define ADCP_CTRL_PD 0
`define ADCP_CTRL_NOISE_INJECT_ENABLE 1
`define ADCP_CTRL_OEN 2
`define ADCP_CTRL_SCR 3
`define ADCP_CTRL_MODE 4
`define ADCP_CTRL_CAP 6
`define ADCP_CTRL_RST 8'h00
`define ADCP_ST_SAMPLE 0
`define ADCP_ST_OVR 1
`define ADCP_ST_W 2
`define ADCP_RESP_OKAY 2'h0
`define ADCP_RESP_SLVERR 2'h2

`endif

/* File: hw/adcp_pkg.sv */
// Purpose: types of the converter output port
// Assumes: nothing
// Notes: constants live in adcp_map.svh
`default_nettype none
package adcp_pkg;
    typedef enum logic [1:0] {
        ADCP_LVL_GND = 2'h0,
        ADCP_LVL_THIRD = 2'h1,
        ADCP_LVL_TWO_THIRDS = 2'h2,
        ADCP_LVL_FULL = 2'h3
    } adcp_level_t;
    typedef enum logic [1:0] {
        ADCP_CAP_STRB_FALL = 2'h0,
        ADCP_CAP_INV_RISE = 2'h1,
        ADCP_CAP_CLK_RISE = 2'h2,
        ADCP_CAP_OFF = 2'h3
    } adcp_cap_t;
    typedef enum logic {
        ADCP_PH_IDLE = 1'b0,
        ADCP_PH_WAIT = 1'b1
    } adcp_phase_t;
endpackage
`default_nettype wire

/* File: hw/adcp_if.sv */
// Purpose: pins between converter and capture logic
// Assumes: four-level mode pin carried as a 2-bit level code
// Notes: released outputs read low
`timescale 1ns/1ns
`default_nettype none
`include "adcp_map.svh"
interface adcp_if;
    logic sample_clk;
    logic power_down_pin;
    logic output_enable_n;
    logic noise_inject_enable;
    logic output_scramble_select;
    logic [1:0] mode_level;
    logic [`ADCP_WORD_W-1:0] word_o;
    logic flag_o;
    logic strb_o;
    logic strb_inv_o;
    logic out_en;
    wire [`ADCP_WORD_W-1:0] sample_word;
    wire range_exceeded_flag;
    wire data_valid_strobe;
    wire data_valid_strobe_inv;

    assign sample_word = out_en ? word_o : '0;
    assign range_exceeded_flag = out_en ? flag_o : 1'b0;
    assign data_valid_strobe = out_en ? strb_o : 1'b0;
    assign data_valid_strobe_inv = out_en ? strb_inv_o : 1'b0;

    modport dev (
        input sample_clk, power_down_pin, output_enable_n,
        input noise_inject_enable, output_scramble_select, mode_level,
        output word_o, flag_o, strb_o, strb_inv_o, out_en
    );
    modport host (
        output sample_clk, power_down_pin, output_enable_n,
        output noise_inject_enable, output_scramble_select, mode_level,
        input sample_word, range_exceeded_flag,
        input data_valid_strobe, data_valid_strobe_inv
    );
endinterface
`default_nettype wire

/* File: hw/adcp_sync.sv */
// Purpose: two-stage synchroniser with edge pulses
// Assumes: inputs from outside the CLOCK domain
// Notes: edges are taken from the second and third stages only
`timescale 1ns/1ns
`default_nettype none
module adcp_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;

    always_comb begin
        s1_d = d;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    assign q = s2_q;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule
`default_nettype wire

/* File: hw/adcp_dev_end.sv */
// Purpose: device end of a 16-bit pipelined converter output port
// Assumes: link pins come from another clock domain; AIN is local
// Notes: sample clock edges are found by sampling it on CLOCK
// How it works
// [R1] hold input on each sample-clock falling edge
// [R2] receiver may latch word on clock rise
// [R3] power-down stops conversion, floats all outputs
// [R4] dither pin high enables internal dither
// [R5] sixteen-bit word, top bit most significant
// [R6] true strobe toggles; receiver latches on fall
// [R7] inverted strobe toggles; receiver latches on rise
// [R8] range flag high on over or underflow
// [R9] output-enable low drives, high floats outputs
// [R10] low two levels offset binary, else two's complement
// [R11] middle mode levels turn stabilizer on
// [R12] scramble select XORs bits 1-15 with bit 0
// [R13] receiver undoes scramble with same XOR
// [R14] result appears seven clock cycles after sampling
// [R15] word, flag, strobes update once per cycle
`timescale 1ns/1ns
`default_nettype none
`include "adcp_map.svh"
module adcp_dev_end #(
    parameter int IN_W = 18,
    parameter int LAT = `ADCP_LATENCY,
    parameter int DCS_HALF = `ADCP_DCS_HALF_CYC
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic signed [IN_W-1:0] AIN,
    output logic CONV_ACTIVE,
    output logic DCS_ON,
    output logic TWOS_FMT,
    adcp_if.dev LINK
);
    // ----------------------------------------
    // constants
    // ----------------------------------------
    localparam int WW = `ADCP_WORD_W;
    localparam int W1 = IN_W + 1;
    localparam int DW = `ADCP_NOISE_INJECT_ENABLE_W;
    localparam int CW = $clog2(DCS_HALF + 1);
    localparam logic signed [W1-1:0] VMAX = W1'((2 ** (WW - 1)) - 1);
    localparam logic signed [W1-1:0] VMIN = W1'(-(2 ** (WW - 1)));

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [6:0] pin_raw, pin_s, pin_r, pin_f;
    logic clk_rise, clk_fall, pd, oen, noise_inject_enable_en, scr, twos, dcs;
    adcp_pkg::adcp_level_t lvl;

    assign pin_raw = {LINK.mode_level, LINK.output_scramble_select,
                      LINK.noise_inject_enable, LINK.output_enable_n,
                      LINK.power_down_pin, LINK.sample_clk};

    adcp_sync #(.W(7)) u_sync (
        .clock(CLOCK),
        .rstn(RSTN),
        .d(pin_raw),
        .q(pin_s),
        .rise(pin_r),
        .fall(pin_f)
    );

    assign clk_rise = pin_r[0];
    assign clk_fall = pin_f[0];
    assign pd = pin_s[1];
    assign oen = pin_s[2];
    assign noise_inject_enable_en = pin_s[3];
    assign scr = pin_s[4];
    assign lvl = adcp_pkg::adcp_level_t'(pin_s[6:5]);

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    assign twos = (lvl == adcp_pkg::ADCP_LVL_TWO_THIRDS) ||
                  (lvl == adcp_pkg::ADCP_LVL_FULL); // R10
    assign dcs = (lvl == adcp_pkg::ADCP_LVL_THIRD) ||
                 (lvl == adcp_pkg::ADCP_LVL_TWO_THIRDS); // R11

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic signed [W1-1:0] pipe_q [LAT];
    logic signed [W1-1:0] pipe_d [LAT];
    logic signed [W1-1:0] dq_q [LAT];
    logic signed [W1-1:0] dq_d [LAT];
    logic [15:0] lfsr_q, lfsr_d;
    adcp_pkg::adcp_phase_t phase_q, phase_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [WW-1:0] word_q, word_d;
    logic flag_q, flag_d, strb_q, strb_d, inv_q, inv_d, oe_q, oe_d;
    logic act_q, act_d, dcs_q, dcs_d, twos_q, twos_d;
    logic update;

    // ----------------------------------------
    // output correction, format, scramble
    // ----------------------------------------
    logic signed [W1-1:0] corr, ain_ext, noise_inject_enable_val;
    logic hi, lo, fb;
    logic [WW-1:0] sat, fmt, out_w;

    assign fb = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];
    assign ain_ext = W1'(AIN);
    // dither is added at hold and removed after the pipe
    assign noise_inject_enable_val = noise_inject_enable_en ? W1'(lfsr_q[DW-1:0]) : '0; // R4
    assign corr = pipe_q[LAT-1] - dq_q[LAT-1];
    assign hi = corr > VMAX; // R8
    assign lo = corr < VMIN; // R8
    assign sat = hi ? VMAX[WW-1:0] : (lo ? VMIN[WW-1:0] : corr[WW-1:0]);
    // offset binary is the sign bit flipped
    assign fmt = twos ? sat : {~sat[WW-1], sat[WW-2:0]}; // R10 R5
    assign out_w[0] = fmt[0];

    genvar b;
    generate
        for (b = 1; b < WW; b++) begin : g_scr
            assign out_w[b] = scr ? (fmt[b] ^ fmt[0]) : fmt[b]; // R12
        end
    endgenerate

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        pipe_d = pipe_q;
        dq_d = dq_q;
        lfsr_d = lfsr_q;
        phase_d = phase_q;
        cnt_d = cnt_q;
        word_d = word_q;
        flag_d = flag_q;
        strb_d = strb_q;
        inv_d = inv_q;
        update = 1'b0;
        oe_d = ~pd & ~oen; // R3 R9
        act_d = ~pd;
        dcs_d = dcs;
        twos_d = twos;
        if (pd) begin
            phase_d = adcp_pkg::ADCP_PH_IDLE; // R3
        end else begin
            if (clk_fall) begin
                lfsr_d = {lfsr_q[14:0], fb};
                for (int i = LAT - 1; i > 0; i--) begin
                    pipe_d[i] = pipe_q[i-1]; // R14
                    dq_d[i] = dq_q[i-1];
                end
                pipe_d[0] = ain_ext + noise_inject_enable_val; // R1
                dq_d[0] = noise_inject_enable_val;
                // mid-word: true strobe falls, inverted one rises
                strb_d = 1'b0; // R6
                inv_d = 1'b1; // R7
            end
            if (dcs) begin
                // stabiliser: own rising edge a fixed half after fall
                unique case (phase_q)
                    adcp_pkg::ADCP_PH_IDLE: begin
                        if (clk_fall) begin
                            phase_d = adcp_pkg::ADCP_PH_WAIT; // R11
                            cnt_d = CW'(DCS_HALF - 1);
                        end
                    end
                    adcp_pkg::ADCP_PH_WAIT: begin
                        if (cnt_q == '0) begin
                            update = 1'b1;
                            phase_d = adcp_pkg::ADCP_PH_IDLE;
                        end else begin
                            cnt_d = cnt_q - 1'b1;
                        end
                    end
                endcase
            end else begin
                phase_d = adcp_pkg::ADCP_PH_IDLE;
                update = clk_rise; // R2
            end
        end
        // a word only ever follows a strobe fall
        if (update && !strb_q) begin
            word_d = out_w; // R15 R5
            flag_d = hi | lo; // R8 R15
            strb_d = 1'b1; // R6
            inv_d = 1'b0; // R7
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            for (int i = 0; i < LAT; i++) begin
                pipe_q[i] <= '0;
                dq_q[i] <= '0;
            end
            lfsr_q <= `ADCP_LFSR_SEED;
            phase_q <= adcp_pkg::ADCP_PH_IDLE;
            cnt_q <= '0;
            word_q <= '0;
            flag_q <= 1'b0;
            strb_q <= 1'b1;
            inv_q <= 1'b0;
            oe_q <= 1'b0;
            act_q <= 1'b0;
            dcs_q <= 1'b0;
            twos_q <= 1'b0;
        end else begin
            pipe_q <= pipe_d;
            dq_q <= dq_d;
            lfsr_q <= lfsr_d;
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            word_q <= word_d;
            flag_q <= flag_d;
            strb_q <= strb_d;
            inv_q <= inv_d;
            oe_q <= oe_d;
            act_q <= act_d;
            dcs_q <= dcs_d;
            twos_q <= twos_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign LINK.word_o = word_q;
    assign LINK.flag_o = flag_q;
    assign LINK.strb_o = strb_q;
    assign LINK.strb_inv_o = inv_q;
    assign LINK.out_en = oe_q;
    assign CONV_ACTIVE = act_q;
    assign DCS_ON = dcs_q;
    assign TWOS_FMT = twos_q;
endmodule
`default_nettype wire

/* File: hw/adcp_host_end.sv */
// Purpose: capture end, AXI4-Lite controlled, latches converter words
// Assumes: word and strobes come from another domain
// Notes: makes the sample clock by a divider of CLOCK
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "adcp_map.svh"
module adcp_host_end #(
    parameter int HALF = `ADCP_LINK_HALF_CYC,
    parameter int ADDR_W = 4
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic IRQ,
    adcp_if.host LINK
);
    localparam int WW = `ADCP_WORD_W;
    localparam int SW = `ADCP_ST_W;
    localparam int HW = $clog2(HALF + 1);

    // ----------------------------------------
    // link synchroniser
    // ----------------------------------------
    logic [WW+2:0] ln_s, ln_r, ln_f;
    adcp_sync #(.W(WW + 3)) u_sync (
        .clock(CLOCK),
        .rstn(RSTN),
        .d({LINK.data_valid_strobe_inv, LINK.data_valid_strobe,
            LINK.range_exceeded_flag, LINK.sample_word}),
        .q(ln_s),
        .rise(ln_r),
        .fall(ln_f)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [WW:0] data_q, data_d;
    logic [SW-1:0] stat_q, stat_d, mask_q, mask_d, st_set, st_clr;
    logic [HW-1:0] div_q, div_d;
    logic sclk_q, sclk_d, own_q, own_d, irq_q, irq_d;
    logic [ADDR_W-1:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0] ws_q, ws_d;
    logic awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic cap, twos;
    logic [WW-1:0] w, ds;
    adcp_pkg::adcp_cap_t sel;

    assign sel = adcp_pkg::adcp_cap_t'(ctrl_q[`ADCP_CTRL_CAP +: 2]);
    assign twos = ctrl_q[`ADCP_CTRL_MODE + 1]; // R10
    assign w = ln_s[WW-1:0];
    assign ds = ctrl_q[`ADCP_CTRL_SCR] ?
        {w[WW-1:1] ^ {(WW - 1){w[0]}}, w[0]} : w; // R13

    always_comb begin
        unique case (sel)
            adcp_pkg::ADCP_CAP_STRB_FALL: cap = ln_f[WW+1]; // R6
            adcp_pkg::ADCP_CAP_INV_RISE: cap = ln_r[WW+2]; // R7
            adcp_pkg::ADCP_CAP_CLK_RISE: cap = own_q; // R2
            adcp_pkg::ADCP_CAP_OFF: cap = 1'b0;
        endcase
        // floating outputs are never latched
        cap = cap & ~ctrl_q[`ADCP_CTRL_PD] & ~ctrl_q[`ADCP_CTRL_OEN];
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        data_d = data_q;
        mask_d = mask_q;
        div_d = div_q + 1'b1;
        sclk_d = sclk_q;
        own_d = 1'b0;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        awh_d = awh_q;
        wh_d = wh_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rr_d = rr_q;
        rd_d = rd_q;
        st_set = '0;
        st_clr = '0;
        if (div_q == HW'(HALF - 1)) begin
            div_d = '0;
            sclk_d = ~sclk_q;
            own_d = ~sclk_q;
        end
        if (cap) begin
            data_d[WW] = ln_s[WW];
            data_d[WW-1:0] = twos ? ds : {~ds[WW-1], ds[WW-2:0]};
            st_set[`ADCP_ST_SAMPLE] = 1'b1;
            st_set[`ADCP_ST_OVR] = ln_s[WW];
        end
        if (AWVALID && !awh_q) begin
            awh_d = 1'b1;
            awa_d = AWADDR;
        end
        if (WVALID && !wh_q) begin
            wh_d = 1'b1;
            wd_d = WDATA;
            ws_d = WSTRB;
        end
        if (BVALID && BREADY) begin
            bv_d = 1'b0;
        end
        if (awh_q && wh_q && !bv_q) begin
            awh_d = 1'b0;
            wh_d = 1'b0;
            bv_d = 1'b1;
            br_d = `ADCP_RESP_OKAY;
            unique case (awa_q)
                `ADCP_REG_CTRL: if (ws_q[0]) ctrl_d = wd_q[7:0];
                `ADCP_REG_DATA: ;
                `ADCP_REG_STAT: if (ws_q[0]) st_clr = wd_q[SW-1:0];
                `ADCP_REG_MASK: if (ws_q[0]) mask_d = wd_q[SW-1:0];
                default: br_d = `ADCP_RESP_SLVERR;
            endcase
        end
        if (RVALID && RREADY) begin
            rv_d = 1'b0;
        end
        if (ARVALID && !rv_q) begin
            rv_d = 1'b1;
            rr_d = `ADCP_RESP_OKAY;
            unique case (ARADDR)
                `ADCP_REG_CTRL: rd_d = {24'h000000, ctrl_q};
                `ADCP_REG_DATA: rd_d = {{(31 - WW){1'b0}}, data_q};
                `ADCP_REG_STAT: rd_d = {{(32 - SW){1'b0}}, stat_q};
                `ADCP_REG_MASK: rd_d = {{(32 - SW){1'b0}}, mask_q};
                default: begin
                    rd_d = 32'h00000000;
                    rr_d = `ADCP_RESP_SLVERR;
                end
            endcase
        end
        // a new event wins over its clear
        stat_d = (stat_q & ~st_clr) | st_set;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ctrl_q <= `ADCP_CTRL_RST;
            data_q <= '0;
            stat_q <= '0;
            mask_q <= '0;
            div_q <= '0;
            sclk_q <= 1'b0;
            own_q <= 1'b0;
            irq_q <= 1'b0;
            awa_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
            awh_q <= 1'b0;
            wh_q <= 1'b0;
            bv_q <= 1'b0;
            br_q <= `ADCP_RESP_OKAY;
            rv_q <= 1'b0;
            rr_q <= `ADCP_RESP_OKAY;
            rd_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            data_q <= data_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            div_q <= div_d;
            sclk_q <= sclk_d;
            own_q <= own_d;
            irq_q <= irq_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            awh_q <= awh_d;
            wh_q <= wh_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign AWREADY = ~awh_q;
    assign WREADY = ~wh_q;
    assign BVALID = bv_q;
    assign BRESP = br_q;
    assign ARREADY = ~rv_q;
    assign RVALID = rv_q;
    assign RDATA = rd_q;
    assign RRESP = rr_q;
    assign IRQ = irq_q;
    assign LINK.sample_clk = sclk_q;
    assign LINK.power_down_pin = ctrl_q[`ADCP_CTRL_PD];
    assign LINK.output_enable_n = ctrl_q[`ADCP_CTRL_OEN];
    assign LINK.noise_inject_enable = ctrl_q[`ADCP_CTRL_NOISE_INJECT_ENABLE];
    assign LINK.output_scramble_select = ctrl_q[`ADCP_CTRL_SCR];
    assign LINK.mode_level = ctrl_q[`ADCP_CTRL_MODE +: 2];
endmodule
`default_nettype wire

/* File: tb/adcp_chk.sv */
// Purpose: link-side assertions for the converter output port
// Assumes: strobes and word are device registers on CLOCK
// Notes: instantiated beside the interface
`timescale 1ns/1ns
`default_nettype none
`include "adcp_map.svh"
module adcp_chk (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic sample_clk,
    input wire logic power_down_pin,
    input wire logic output_enable_n,
    input wire logic [1:0] mode_level,
    input wire logic [`ADCP_WORD_W-1:0] word_o,
    input wire logic flag_o,
    input wire logic strb_o,
    input wire logic strb_inv_o,
    input wire logic out_en
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    property p_inv; strb_inv_o == !strb_o; endproperty
    property p_oe; output_enable_n [*4] |-> !out_en; endproperty
    property p_pd; power_down_pin [*4] |-> !out_en; endproperty
    property p_en;
        (!power_down_pin && !output_enable_n) [*5] |-> out_en;
    endproperty
    property p_frz; power_down_pin [*5] |-> $stable(strb_o); endproperty
    property p_fall;
        $fell(sample_clk) && out_en |-> ##[2:5] (!strb_o || power_down_pin);
    endproperty
    property p_rise;
        $rose(sample_clk) && out_en && mode_level == 2'h0
            |-> ##[2:5] (strb_o || power_down_pin);
    endproperty
    property p_word; $changed(word_o) |-> $rose(strb_o); endproperty
    property p_flag; $changed(flag_o) |-> $rose(strb_o); endproperty
    property p_rate; $rose(strb_o) |=> (!$rose(strb_o)) [*5]; endproperty
    a_inv: assert property (p_inv) else $error("strobes not inverse");
    a_oe: assert property (p_oe) else $error("driven with oe high");
    a_pd: assert property (p_pd) else $error("driven in power down");
    a_en: assert property (p_en) else $error("outputs not driven");
    a_frz: assert property (p_frz) else $error("strobe in power down");
    a_fall: assert property (p_fall) else $error("no strobe fall");
    a_rise: assert property (p_rise) else $error("no strobe rise");
    a_word: assert property (p_word) else $error("word off strobe");
    a_flag: assert property (p_flag) else $error("flag off strobe");
    a_rate: assert property (p_rate) else $error("strobe too fast");
    c_upd: cover property ($rose(strb_o) && out_en);
    c_pd: cover property (power_down_pin && !out_en);
    c_off: cover property ($fell(out_en));
endmodule
`default_nettype wire

/* File: tb/adc_parallel_output_port_tb.sv */
// Purpose: bench joining both ends of the converter output port
// Assumes: host end makes the sample clock
// Notes: controller reached over AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
`include "adcp_map.svh"
module adc_parallel_output_port_tb;
    // ----------------------------------------
    // wiring
    // ----------------------------------------
    localparam logic [3:0] CT = `ADCP_REG_CTRL, DT = `ADCP_REG_DATA;
    localparam logic [3:0] ST = `ADCP_REG_STAT, MK = `ADCP_REG_MASK;
    localparam logic [1:0] OK = `ADCP_RESP_OKAY, SE = `ADCP_RESP_SLVERR;
    logic clock = 1'b0, rstn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic signed [17:0] ain = 18'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, act, dcs, twos;
    logic [1:0] bresp, rresp;
    int failures = 0, checks = 0;
    adcp_if link ();
    adcp_dev_end adcp_dev_end_inst (.CLOCK(clock), .RSTN(rstn), .AIN(ain),
        .CONV_ACTIVE(act), .DCS_ON(dcs), .TWOS_FMT(twos), .LINK(link));
    adcp_host_end adcp_host_end_inst (.CLOCK(clock), .RSTN(rstn),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready), .IRQ(irq), .LINK(link));
    adcp_chk adcp_chk_inst (.CLOCK(clock), .RSTN(rstn),
        .sample_clk(link.sample_clk), .power_down_pin(link.power_down_pin),
        .output_enable_n(link.output_enable_n), .mode_level(link.mode_level),
        .word_o(link.word_o), .flag_o(link.flag_o), .strb_o(link.strb_o),
        .strb_inv_o(link.strb_inv_o), .out_en(link.out_en));
    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(OK));
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e,
        input logic [1:0] re);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk(32'(rresp), 32'(re));
    endtask
    // waits for word updates, then lets them settle
    task automatic upd(input int n);
        repeat (n) @(posedge link.strb_o);
        #1;
    endtask
    task automatic t_mode;
        logic [15:0] v;
        for (int l = 0; l < 4; l++) begin
            v = 16'h1230 + 16'(l);
            ain <= 18'(v);
            wr(CT, 32'(l) << `ADCP_CTRL_MODE);
            upd(10);
            chk(32'(link.sample_word), 32'(l > 1 ? v : v ^ 16'h8000));
            chk(32'(twos), 32'(l > 1));
            chk(32'(dcs), 32'(l == 1 || l == 2));
            rdc(DT, 32'(v), OK);
        end
        $display("test mode done");
    endtask
    task automatic t_lat;
        int n;
        ain <= 18'h00100;
        wr(CT, 32'h32);
        upd(10);
        @(posedge link.sample_clk);
        ain <= 18'h00555;
        @(negedge link.sample_clk);
        n = 0;
        do begin
            upd(1);
            n++;
        end while (link.sample_word !== 16'h0555 && n < 20);
        chk(32'(n), 32'(`ADCP_LATENCY));
        upd(1);
        rdc(DT, 32'h0555, OK);
        ain <= 18'h00a5b;
        wr(CT, 32'h38);
        upd(10);
        chk(32'(link.sample_word), 32'hf5a5);
        rdc(DT, 32'h0a5b, OK);
        $display("test latency done");
    endtask
    task automatic t_ovr;
        ain <= 18'h10000;
        wr(CT, 32'h30);
        wr(MK, 32'h2);
        upd(10);
        chk(32'(link.range_exceeded_flag), 32'h1);
        chk(32'(link.sample_word), 32'h7fff);
        rdc(DT, 32'h17fff, OK);
        chk(32'(irq), 32'h1);
        wr(MK, 32'h0);
        rdc(ST, 32'h3, OK);
        chk(32'(irq), 32'h0);
        wr(CT, 32'hf0);
        upd(2);
        wr(ST, 32'h3);
        wr(MK, 32'h3);
        rdc(ST, 32'h0, OK);
        chk(32'(irq), 32'h0);
        $display("test range done");
    endtask
    task automatic t_off;
        wr(CT, 32'h04);
        upd(2);
        chk(32'(link.sample_word), 32'h0);
        chk(32'(link.data_valid_strobe), 32'h0);
        wr(CT, 32'h01);
        rdc(CT, 32'h1, OK);
        rdc(4'h2, 32'h0, SE);
        chk(32'(act), 32'h0);
        chk(32'(link.range_exceeded_flag), 32'h0);
        wr(CT, 32'h30);
        upd(2);
        chk(32'(act), 32'h1);
        chk(32'(link.sample_word), 32'h7fff);
        $display("test output off done");
    endtask
    task automatic t_cap;
        for (int c = 0; c < 3; c++) begin
            wr(CT, 32'h30 | (32'(c) << `ADCP_CTRL_CAP));
            ain <= 18'(16'h0200 + 16'(c));
            upd(10);
            rdc(DT, 32'h0200 + 32'(c), OK);
        end
        $display("test capture done");
    endtask
    initial begin
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        rdc(CT, 32'h0, OK);
        t_mode;
        t_lat;
        t_ovr;
        t_off;
        t_cap;
        end_sim;
    end
    initial begin
        repeat (40000) @(posedge clock);
        failures++;
        end_sim;
    end
endmodule
`default_nettype wire
